// *** common/supply_integrity_pkg.sv ***
package supply_integrity_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int APB_AW = 8;
	localparam logic [APB_AW-1:0] CTRL_STATUS_ADDR = 8'h00;
	localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;

	// field positions inside the control/status byte
	localparam int BIT_SRC_SEL = 7;
	localparam int BIT_IRQ_EN = 6;
	localparam int BIT_AUX_FLAG = 5;
	localparam int BIT_LSR_FLAG = 4;
	localparam int BIT_WDG_FLAG = 0;

	// ---------------------------------------------------------------
	// timing: post-reset delay in cpu clock cycles
	// ---------------------------------------------------------------
	localparam int CNT_W = 13;
	localparam logic [CNT_W-1:0] DELAY_SHORT_CYC = 13'h0100;
	localparam logic [CNT_W-1:0] DELAY_LONG_CYC = 13'h1000;

	// threshold encodings of the low-supply detector
	localparam logic [1:0] LEVEL_LOW = 2'h0;
	localparam logic [1:0] LEVEL_MEDIUM = 2'h1;
	localparam logic [1:0] LEVEL_HIGH = 2'h2;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum {RST_ACTIVE, RST_DELAY, RST_RUN} seq_state_t;

	typedef struct packed {
		logic lsd_enable;
		logic [1:0] lsd_level;
		logic long_delay;
	} option_cfg_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [APB_AW-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

endpackage : supply_integrity_pkg

// *** src/supply_integrity_monitor.sv ***
`timescale 1ns/1ps

module supply_integrity_monitor
	import supply_integrity_pkg::*;
#(
	parameter logic [CNT_W-1:0] SHORT_DELAY = DELAY_SHORT_CYC,
	parameter logic [CNT_W-1:0] LONG_DELAY = DELAY_LONG_CYC
) (
	input wire logic clk, // cpu clock
	input wire logic ce, // clock enable, freezes all state
	input wire logic sys_rst, // power-on reset, active high
	input wire apb_req_t apb_req, // apb request from master
	output apb_rsp_t apb_rsp, // apb answer
	input wire option_cfg_t cfg, // non-volatile option settings
	input wire logic lsd_below_raw, // supply comparator, async
	input wire logic aux_below_raw, // aux comparator, async
	input wire logic wdg_reset_req, // watchdog underflow, same clock
	input wire logic rst_pin_in, // reset pin level, async
	output logic rst_pin_out, // reset pin drive value
	output logic rst_pin_oe, // reset pin drive enable
	output logic chip_reset, // holds the chip in reset
	output logic [1:0] lsd_level, // threshold to the comparator
	output logic aux_src_sel, // aux source to the comparator
	input wire logic halt_mode, // cpu in halt
	input wire logic isr_ack, // cpu enters aux service routine
	input wire logic cpu_irq_mask, // cpu interrupt mask set
	output logic aux_irq, // request to the cpu
	output logic aux_wake // wake request out of wait
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	logic [2:0] oe_hist_ff;
	seq_state_t state_ff;
	seq_state_t nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic src_ff;
	logic ie_ff;
	logic aux_flag_ff;
	logic lsr_flag_ff;
	logic wdg_flag_ff;
	logic pend_ff;
	logic nxt_src;
	logic nxt_ie;
	logic nxt_aux_flag;
	logic nxt_lsr;
	logic nxt_wdg;
	logic nxt_pend;
	apb_rsp_t rsp_ff;
	apb_rsp_t nxt_rsp;
	logic pin_oe_ff;
	logic pin_out_ff;
	logic chip_rst_ff;
	logic [1:0] level_ff;
	logic irq_ff;
	logic wake_ff;

	// ---------------------------------------------------------------
	// synchroniser for comparator and pin inputs
	// ---------------------------------------------------------------

	// bit 0 supply, bit 1 aux, bit 2 reset pin
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_ff <= 3'h4;
			sync2_ff <= 3'h4;
		end else if (ce) begin
			sync1_ff <= {rst_pin_in, aux_below_raw, lsd_below_raw};
			sync2_ff <= sync1_ff;
		end
	end

	// ---------------------------------------------------------------
	// reset sources
	// ---------------------------------------------------------------

	// detector off means its comparator is ignored
	wire lsd_en = cfg.lsd_enable;
	wire lsd_low = sync2_ff[0] & lsd_en;
	wire aux_low = sync2_ff[1] & lsd_en;

	// our own pin drive reads back low; ignore it until it settles
	wire own_drive = |oe_hist_ff;
	wire pin_low = ~sync2_ff[2] & ~own_drive;
	wire any_src = lsd_low | wdg_reset_req | pin_low;
	wire in_rst = (state_ff != RST_RUN);

	// delay length picked by the option setting
	wire [CNT_W-1:0] delay_len = cfg.long_delay ? LONG_DELAY : SHORT_DELAY;

	// ---------------------------------------------------------------
	// reset sequence: active phase, delay, run
	// ---------------------------------------------------------------

	// any live source restarts the active phase
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		if (any_src) begin
			nxt_state = RST_ACTIVE;
		end else begin
			unique case (state_ff)
				RST_ACTIVE: begin
					nxt_state = RST_DELAY;
					nxt_cnt = delay_len - 13'h0001;
				end
				RST_DELAY: begin
					if (cnt_ff == '0) begin
						nxt_state = RST_RUN;
					end else begin
						nxt_cnt = cnt_ff - 13'h0001;
					end
				end
				RST_RUN: begin
					nxt_state = RST_RUN;
				end
			endcase
		end
	end

	// sequencer state, runs even in halt so a reset exits it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= RST_ACTIVE;
			cnt_ff <= '0;
		end else if (ce) begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	wire acc = apb_req.psel & apb_req.penable;
	wire hit = (apb_req.paddr == CTRL_STATUS_ADDR);
	wire wr_done = acc & rsp_ff.pready & apb_req.pwrite & hit;

	// halt freezes the register against writes
	wire wr_ok = wr_done & ~halt_mode & ~in_rst;
	wire [7:0] wdat = apb_req.pwdata[7:0];
	wire upd = ~halt_mode;

	// ---------------------------------------------------------------
	// control bits
	// ---------------------------------------------------------------

	// software read/write bits, cleared by any chip reset
	assign nxt_src = in_rst ? 1'b0 : (wr_ok ? wdat[BIT_SRC_SEL] : src_ff);
	assign nxt_ie = in_rst ? 1'b0 : (wr_ok ? wdat[BIT_IRQ_EN] : ie_ff);

	// ---------------------------------------------------------------
	// aux flag and request
	// ---------------------------------------------------------------

	// flag tracks comparator; bus writes never reach it
	assign nxt_aux_flag = upd ? aux_low : aux_flag_ff;
	wire aux_edge = upd & (aux_low != aux_flag_ff);

	// enabling raises one request whatever the flag value
	wire ie_set = wr_ok & wdat[BIT_IRQ_EN] & ~ie_ff;
	wire ev_ok = lsd_en & ~in_rst & upd;
	wire set_pend = ev_ok & ((aux_edge & ie_ff) | ie_set);

	// set beats the service-entry clear
	assign nxt_pend = in_rst ? 1'b0 :
		(set_pend ? 1'b1 : (isr_ack ? 1'b0 : pend_ff));

	// ---------------------------------------------------------------
	// reset source flags
	// ---------------------------------------------------------------
	// halt freezes the flags against software clears too
	wire wr_clr_lsr = wr_done & ~halt_mode & ~wdat[BIT_LSR_FLAG];
	wire wr_clr_wdg = wr_done & ~halt_mode & ~wdat[BIT_WDG_FLAG];

	// supply flag: only a write of zero or power-on clears it
	assign nxt_lsr = lsd_low ? 1'b1 : (wr_clr_lsr ? 1'b0 : lsr_flag_ff);

	// watchdog flag: supply reset wins, then set, then write
	assign nxt_wdg = lsd_low ? 1'b0 :
		(wdg_reset_req ? 1'b1 : (wr_clr_wdg ? 1'b0 : wdg_flag_ff));

	// register image, reserved bits read zero
	wire [7:0] reg_img = {src_ff, ie_ff, aux_flag_ff, lsr_flag_ff, 3'h0, wdg_flag_ff};

	// register storage
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			src_ff <= CTRL_STATUS_RESET[BIT_SRC_SEL];
			ie_ff <= CTRL_STATUS_RESET[BIT_IRQ_EN];
			aux_flag_ff <= CTRL_STATUS_RESET[BIT_AUX_FLAG];
			pend_ff <= 1'b0;
		end else if (ce) begin
			src_ff <= nxt_src;
			ie_ff <= nxt_ie;
			aux_flag_ff <= nxt_aux_flag;
			pend_ff <= nxt_pend;
		end
	end

	// flags survive pin and watchdog resets; a supply reset clears the watchdog flag; power-on clears both
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lsr_flag_ff <= CTRL_STATUS_RESET[BIT_LSR_FLAG];
			wdg_flag_ff <= CTRL_STATUS_RESET[BIT_WDG_FLAG];
		end else if (ce) begin
			lsr_flag_ff <= nxt_lsr;
			wdg_flag_ff <= nxt_wdg;
		end
	end

	// ---------------------------------------------------------------
	// apb answer: ready on the second access cycle
	// ---------------------------------------------------------------
	always_comb begin
		nxt_rsp = '0;
		if (acc & ~rsp_ff.pready) begin
			nxt_rsp.pready = 1'b1;
			nxt_rsp.pslverr = ~hit;
			if (hit & ~apb_req.pwrite) begin
				nxt_rsp.prdata = {24'h000000, reg_img};
			end
		end
	end

	// answer register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rsp_ff <= '0;
		end else if (ce) begin
			rsp_ff <= nxt_rsp;
		end
	end

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------

	// pin and chip reset follow the next sequencer state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_oe_ff <= 1'b1;
			pin_out_ff <= 1'b0;
			chip_rst_ff <= 1'b1;
			oe_hist_ff <= 3'h7;
		end else if (ce) begin
			pin_oe_ff <= (nxt_state != RST_RUN);
			pin_out_ff <= 1'b0;
			chip_rst_ff <= (nxt_state != RST_RUN);
			oe_hist_ff <= {oe_hist_ff[1:0], pin_oe_ff};
		end
	end

	// request gating and analog controls
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_ff <= 1'b0;
			wake_ff <= 1'b0;
			level_ff <= LEVEL_LOW;
		end else if (ce) begin
			irq_ff <= nxt_pend & nxt_ie & ~cpu_irq_mask;
			wake_ff <= nxt_pend & nxt_ie & ~halt_mode;
			level_ff <= cfg.lsd_level;
		end
	end

	assign apb_rsp = rsp_ff;
	assign rst_pin_oe = pin_oe_ff;
	assign rst_pin_out = pin_out_ff;
	assign chip_reset = chip_rst_ff;
	assign lsd_level = level_ff;
	assign aux_src_sel = src_ff;
	assign aux_irq = irq_ff;
	assign aux_wake = wake_ff;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_lsd_hold: assert property (
		ce && lsd_low |=> chip_reset && rst_pin_oe && !rst_pin_out
	) else $error("supply low without chip reset");

	a_lsd_off: assert property (
		ce && !cfg.lsd_enable && !wdg_reset_req && !pin_low |=> state_ff != RST_ACTIVE
	) else $error("disabled detector caused reset");

	a_delay_end: assert property (
		ce && !any_src && state_ff == RST_DELAY && cnt_ff == '0 |=> !in_rst
	) else $error("delay did not end at zero");

	a_delay_load: assert property (
		ce && !any_src && state_ff == RST_ACTIVE |=> cnt_ff == $past(delay_len) - 13'h0001
	) else $error("delay count loaded wrong");

	a_flag_track: assert property (
		ce && !halt_mode |=> aux_flag_ff == $past(sync2_ff[1] & cfg.lsd_enable)
	) else $error("aux flag does not follow comparator");

	a_edge_req: assert property (
		ce && aux_edge && ie_ff && ev_ok |=> pend_ff
	) else $error("flag change raised no request");

	a_quiet_reset: assert property (
		ce && in_rst |=> !pend_ff && !aux_irq
	) else $error("request during reset sequence");

	a_ack_clear: assert property (
		ce && isr_ack && !set_pend |=> !pend_ff
	) else $error("request not cleared on service entry");

	a_halt_freeze: assert property (
		ce && halt_mode && !in_rst && !any_src |=> $stable(src_ff) && $stable(ie_ff)
		&& $stable(aux_flag_ff) && $stable(lsr_flag_ff) && $stable(wdg_flag_ff)
	) else $error("register changed in halt");

	a_irq_gate: assert property (
		ce && (cpu_irq_mask || !nxt_ie) |=> !aux_irq
	) else $error("request reached masked cpu");

	a_lsr_set: assert property (
		ce && lsd_low |=> lsr_flag_ff && !wdg_flag_ff ##1 ce |-> lsr_flag_ff
	) else $error("supply reset flags wrong");

	a_wdg_set: assert property (
		ce && wdg_reset_req && !lsd_low |=> wdg_flag_ff
	) else $error("watchdog flag not set");

	a_level_copy: assert property (
		ce |=> lsd_level == $past(cfg.lsd_level)
	) else $error("threshold level not passed on");

	a_src_write: assert property (
		ce && wr_ok |=> aux_src_sel == $past(apb_req.pwdata[BIT_SRC_SEL])
	) else $error("source select write lost");

	a_enable_req: assert property (
		ce && wr_ok && ev_ok && wdat[BIT_IRQ_EN] && !ie_ff |=> pend_ff && ie_ff
	) else $error("enable gave no request");

	a_halt_nowake: assert property (
		ce && halt_mode |=> !aux_wake
	) else $error("wake request during halt");

endmodule : supply_integrity_monitor

// *** dv/cpu_model.sv ***
`timescale 1ns/1ps
module cpu_model (
	input wire logic clk, // cpu clock
	input wire logic sys_rst, // power-on reset
	input wire logic aux_irq, // request from the monitor
	input wire logic [3:0] ack_delay, // cycles before the routine is entered
	output logic isr_ack // pulse on routine entry
);
	logic [3:0] wait_ff;
	logic busy_ff;

	// enter the routine after ack_delay cycles; hold off until the request drops
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wait_ff <= 4'h0;
			busy_ff <= 1'b0;
			isr_ack <= 1'b0;
		end else begin
			isr_ack <= 1'b0;
			if (busy_ff) begin
				busy_ff <= aux_irq;
			end else if (aux_irq && wait_ff == ack_delay) begin
				isr_ack <= 1'b1;
				busy_ff <= 1'b1;
				wait_ff <= 4'h0;
			end else begin
				wait_ff <= aux_irq ? wait_ff + 4'h1 : 4'h0;
			end
		end
	end
endmodule : cpu_model

// *** dv/supply_integrity_monitor_test.sv ***
`timescale 1ns/1ps
module supply_integrity_monitor_test;
	import supply_integrity_pkg::*;
	logic clk, ce, sys_rst, lsd_below_raw, aux_below_raw, wdg_reset_req, halt_mode;
	logic cpu_irq_mask, rst_pin_out, rst_pin_oe, chip_reset, aux_src_sel;
	logic aux_irq, aux_wake, isr_ack, err;
	logic [1:0] lsd_level;
	logic [3:0] ack_delay;
	logic [31:0] rd;
	logic [APB_AW-1:0] addr;
	wire logic pin_level;
	apb_req_t req;
	apb_rsp_t rsp;
	option_cfg_t cfg;
	int num_errors, n_checks, n;

	// open-drain reset pin with its pull-up
	assign pin_level = (rst_pin_oe && !rst_pin_out) ? 1'b0 : 1'b1;

	supply_integrity_monitor #(.SHORT_DELAY(13'h0008), .LONG_DELAY(13'h0010)) dut (
		.clk(clk), .ce(ce), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp), .cfg(cfg),
		.lsd_below_raw(lsd_below_raw), .aux_below_raw(aux_below_raw),
		.wdg_reset_req(wdg_reset_req), .rst_pin_in(pin_level), .rst_pin_out(rst_pin_out),
		.rst_pin_oe(rst_pin_oe), .chip_reset(chip_reset), .lsd_level(lsd_level),
		.aux_src_sel(aux_src_sel), .halt_mode(halt_mode), .isr_ack(isr_ack),
		.cpu_irq_mask(cpu_irq_mask), .aux_irq(aux_irq), .aux_wake(aux_wake));

	cpu_model cpu (.clk(clk), .sys_rst(sys_rst), .aux_irq(aux_irq), .ack_delay(ack_delay),
		.isr_ack(isr_ack));

	// free-running cpu clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic report_and_stop;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// one apb transfer, held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		req.psel <= 1'b1;
		req.pwrite <= wr;
		req.paddr <= addr;
		req.pwdata <= {24'h0, wd};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (rsp.pready !== 1'b1 && k < 20);
		chk(32'(rsp.pready), 32'h1, "apb answer");
		if (rsp.pready !== 1'b1) report_and_stop();
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic rd_expect(input logic [7:0] exp, input string what);
		apb(1'b0, 8'h00);
		chk(rd, {24'h0, exp}, what);
	endtask : rd_expect

	task automatic wait_run;
		n = 0;
		while (chip_reset !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(32'(chip_reset), 32'h0, "reset sequence ended");
		if (chip_reset !== 1'b0) report_and_stop();
	endtask : wait_run

	// expect one request (or none) and let the cpu model serve it
	task automatic serve(input logic exp, input string what);
		int k;
		k = 0;
		while (aux_irq !== 1'b1 && k < 30) begin
			@(posedge clk);
			k++;
		end
		chk(32'(aux_irq), 32'(exp), what);
		if (exp && aux_irq !== 1'b1) report_and_stop();
		while (aux_irq !== 1'b0 && k < 60) begin
			@(posedge clk);
			k++;
		end
		chk(32'(aux_irq), 32'h0, "request cleared by routine entry");
		if (aux_irq !== 1'b0) report_and_stop();
	endtask : serve

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_values;
		wait_run();
		rd_expect(8'h00, "reset value");
		chk(32'(lsd_level), 32'(LEVEL_HIGH), "threshold level");
		addr = 8'h04;
		apb(1'b0, 8'h00);
		addr = CTRL_STATUS_ADDR;
		chk({rd[31:1], err}, 32'h1, "unmapped address refused");
	endtask : t_reset_values

	task automatic t_aux_events;
		ack_delay <= 4'h9;
		apb(1'b1, 8'h40); // reserved bits kept zero
		serve(1'b1, "request on enable");
		aux_below_raw <= 1'b1;
		serve(1'b1, "request on falling crossing");
		rd_expect(8'h60, "flag below threshold");
		aux_below_raw <= 1'b0;
		serve(1'b1, "request on rising crossing");
		rd_expect(8'h40, "flag above threshold");
		apb(1'b1, 8'h60);
		rd_expect(8'h40, "flag write ignored");
		serve(1'b0, "no request without change");
		apb(1'b1, 8'h00);
		aux_below_raw <= 1'b1;
		serve(1'b0, "no request when disabled");
		aux_below_raw <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : t_aux_events

	task automatic t_source_mask_halt;
		ack_delay <= 4'h0;
		apb(1'b1, 8'hC0);
		@(posedge clk);
		chk(32'(aux_src_sel), 32'h1, "source select pin");
		serve(1'b1, "request on enable");
		cpu_irq_mask <= 1'b1;
		aux_below_raw <= 1'b1;
		repeat (8) @(posedge clk);
		chk(32'(aux_irq), 32'h0, "masked request held back");
		chk(32'(aux_wake), 32'h1, "wake from wait");
		halt_mode <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'(aux_wake), 32'h0, "no wake from halt");
		apb(1'b1, 8'h00);
		@(posedge clk);
		chk(32'(aux_src_sel), 32'h1, "register frozen in halt");
		halt_mode <= 1'b0;
		cpu_irq_mask <= 1'b0;
		serve(1'b1, "request after unmask");
		aux_below_raw <= 1'b0;
		serve(1'b1, "request on rising crossing, pin source");
		rd_expect(8'hC0, "control bits after halt");
		apb(1'b1, 8'h00);
	endtask : t_source_mask_halt

	task automatic t_reset_flags;
		wdg_reset_req <= 1'b1;
		@(posedge clk);
		wdg_reset_req <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'(chip_reset && !pin_level), 32'h1, "watchdog reset drives pin");
		wait_run();
		chk(32'(n >= 8 && n <= 16), 32'h1, "post-reset delay length");
		rd_expect(8'h01, "watchdog flag set");
		lsd_below_raw <= 1'b1;
		repeat (3) @(posedge clk);
		repeat (12) begin
			@(posedge clk);
			chk(32'(chip_reset && !pin_level), 32'h1, "supply reset and pin low");
		end
		lsd_below_raw <= 1'b0;
		wait_run();
		rd_expect(8'h10, "supply flag set, watchdog flag cleared");
		wdg_reset_req <= 1'b1;
		@(posedge clk);
		wdg_reset_req <= 1'b0;
		repeat (3) @(posedge clk);
		wait_run();
		rd_expect(8'h11, "supply flag kept over watchdog reset");
		apb(1'b1, 8'h00);
		rd_expect(8'h00, "flags cleared by writing zero");
	endtask : t_reset_flags

	task automatic t_detector_off;
		sys_rst <= 1'b1;
		cfg.lsd_enable <= 1'b0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		wait_run();
		lsd_below_raw <= 1'b1;
		aux_below_raw <= 1'b1;
		repeat (10) @(posedge clk);
		chk(32'(chip_reset), 32'h0, "disabled detector gives no reset");
		apb(1'b0, 8'h00);
		chk(rd & 32'h20, 32'h0, "aux detector idle when disabled");
	endtask : t_detector_off

	// main sequence
	initial begin
		ce = 1'b1;
		sys_rst = 1'b1;
		req = '0;
		addr = CTRL_STATUS_ADDR;
		cfg = '{lsd_enable: 1'b1, lsd_level: LEVEL_HIGH, long_delay: 1'b0};
		lsd_below_raw = 1'b0;
		aux_below_raw = 1'b0;
		wdg_reset_req = 1'b0;
		halt_mode = 1'b0;
		cpu_irq_mask = 1'b0;
		ack_delay = 4'h3;
		num_errors = 0;
		n_checks = 0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset_values();
		t_aux_events();
		t_source_mask_halt();
		t_reset_flags();
		t_detector_off();
		report_and_stop();
	end
endmodule : supply_integrity_monitor_test
